// ### bench/dtc_pins.sv
`timescale 1ns/1ps
// far-side model: external count pins and gate inputs of both timers
module dtc_pins (
  input  wire logic ref_clk,
  output logic      pin_0,
  output logic      pin_1,
  output logic      gate_0,
  output logic      gate_1
);
  logic [1:0] pin = 2'b11;
  logic [1:0] gt  = 2'b00;

  // pins idle high, a count is a high-to-low step
  assign pin_0  = pin[0];
  assign pin_1  = pin[1];
  assign gate_0 = gt[0];
  assign gate_1 = gt[1];

  // each level held four clocks so the two-flop synchroniser sees it
  task automatic fall(input int i, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      pin[i] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      pin[i] <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  // gate level change, then settle through the synchroniser
  task automatic gate(input int i, input logic v);
    @(posedge ref_clk);
    gt[i] <= v;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
// self-checking bench of the dual counter/timer block
module testbench;
  import dtc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic        vack0   = 1'b0;
  logic        vack1   = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq_a;
  logic        irq_b;
  logic        irq;
  wire         pin0, pin1, gate_enable_bit, gate1;
  logic [31:0] rd;
  logic [7:0]  h;
  logic [7:0]  l;
  int          err_count  = 0;
  int          n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  dtc_timer u_dut (.REF_CLK(ref_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .COUNT_PIN_0(pin0),
    .COUNT_PIN_1(pin1), .EXT_IRQ_INPUT_0(gate_enable_bit), .EXT_IRQ_INPUT_1(gate1),
    .VEC_ACK_0(vack0), .VEC_ACK_1(vack1), .TIMER_A_IRQ(irq_a), .TIMER_B_IRQ(irq_b), .IRQ(irq));
  dtc_pins u_pins (.ref_clk(ref_clk), .pin_0(pin0), .pin_1(pin1), .gate_0(gate_enable_bit), .gate_1(gate1));

  // ----------------------------------------------------------
  // compare, bus and verdict helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    chk({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask

  task automatic summarize;
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ready and read data are taken as they stood at the rising edge
  task automatic wait_rdy;
    int t;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    rd = hrdata;
    if (hreadyout !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t bus hang", $time);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // timer 0 in timer mode for n cycles; count left in h and l
  task automatic run_cnt(input logic [7:0] md, input logic [7:0] ck, input logic [7:0] p, input int n);
    wr(OFS_MODE, md);
    wr(OFS_CLK, ck);
    wr(OFS_C0H, p);
    wr(OFS_C0L, p);
    wr(OFS_CTL, 8'h10);
    repeat (n) @(posedge ref_clk);
    wr(OFS_CTL, 8'h00);
    rdr(OFS_C0H);
    h = rd[7:0];
    rdr(OFS_C0L);
    l = rd[7:0];
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    for (int a = 0; a <= 8'h3C; a += 4) begin
      rdr(8'(a));
      // level-type external flags follow the low gate inputs, active low by default
      chk(rd, (8'(a) == OFS_CTL) ? 32'h0A : 32'h0);
    end
  endtask

  task automatic t_wrap;
    wr(OFS_MODE, 8'h00);
    wr(OFS_CLK, 8'h04);
    wr(OFS_C0H, 8'hFF);
    wr(OFS_C0L, 8'h1F);
    rdr(OFS_C0L);
    chk(rd & 32'h1F, 32'h1F);
    wr(OFS_IEN, 8'h02);
    wr(OFS_IMSK, 8'h01);
    wr(OFS_CTL, 8'h10);
    rdr(OFS_CTL);
    chk(rd, 32'h3A);
    chk({31'h0, irq_a}, 32'h1);
    rdr(OFS_ISTS);
    chk(rd, 32'h1);
    wr(OFS_IMSK, 8'h00);
    #1 chk({31'h0, irq}, 32'h0);
    wr(OFS_IMSK, 8'h01);
    #1 chk({31'h0, irq}, 32'h1);
    wr(OFS_ISTS, 8'h01);
    #1 chk({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    vack0 <= 1'b1;
    @(posedge ref_clk);
    vack0 <= 1'b0;
    #1 chk({31'h0, irq_a}, 32'h0);
    rdr(OFS_CTL);
    chk(rd, 32'h1A);
    wr(OFS_CTL, 8'h20);
    #1 chk({31'h0, irq_a}, 32'h1);
    rdr(OFS_C0H);
    chk(rd, 32'h0);
    wr(OFS_IEN, 8'h00);
    #1 chk({31'h0, irq_a}, 32'h0);
    wr(OFS_CTL, 8'h00);
  endtask

  task automatic t_count1;
    wr(OFS_MODE, 8'h40);
    wr(OFS_C1H, 8'h00);
    wr(OFS_C1L, 8'h1E);
    wr(OFS_CTL, 8'h40);
    u_pins.fall(1, 3);
    u_pins.fall(0, 2);
    rdr(OFS_C1L);
    chk(rd & 32'h1F, 32'h01);
    rdr(OFS_C1H);
    chk(rd, 32'h01);
    // timer 1 wrap raises its own request, vectoring clears it
    wr(OFS_IEN, 8'h08);
    wr(OFS_C1H, 8'hFF);
    wr(OFS_C1L, 8'h1F);
    u_pins.fall(1, 1);
    chk({31'h0, irq_b}, 32'h1);
    rdr(OFS_C1H);
    chk(rd, 32'h0);
    @(posedge ref_clk);
    vack1 <= 1'b1;
    @(posedge ref_clk);
    vack1 <= 1'b0;
    #1 chk({31'h0, irq_b}, 32'h0);
    wr(OFS_IEN, 8'h00);
    wr(OFS_CTL, 8'h00);
  endtask

  task automatic t_gate;
    wr(OFS_MODE, 8'h0C);
    wr(OFS_ECFG, 8'h08);
    wr(OFS_C0L, 8'h00);
    wr(OFS_C0H, 8'h00);
    wr(OFS_CTL, 8'h10);
    u_pins.fall(0, 2);
    rdr(OFS_C0L);
    chk(rd & 32'h1F, 32'h0);
    u_pins.gate(0, 1'b1);
    u_pins.fall(0, 2);
    rdr(OFS_C0L);
    chk(rd & 32'h1F, 32'h2);
    wr(OFS_ECFG, 8'h00);
    u_pins.fall(0, 1);
    rdr(OFS_C0L);
    chk(rd & 32'h1F, 32'h2);
    wr(OFS_CTL, 8'h00);
    u_pins.gate(0, 1'b0);
    u_pins.fall(0, 1);
    rdr(OFS_C0L);
    chk(rd & 32'h1F, 32'h2);
    wr(OFS_CTL, 8'h10);
    u_pins.fall(0, 1);
    rdr(OFS_C0L);
    chk(rd & 32'h1F, 32'h3);
    wr(OFS_CTL, 8'h00);
  endtask

  task automatic t_modes;
    logic [PSC_W-1:0] dv [4] = '{DIV_0, DIV_1, DIV_2, DIV_3};
    for (int s = 0; s < 4; s++) begin
      run_cnt(8'h00, 8'(s), 8'h00, 64);
      rng({3'h0, h, l[4:0]}, 16'(64 / dv[s]), 16'(64 / dv[s] + 2));
    end
    run_cnt(8'h00, 8'h04, 8'h00, 40);
    rng({3'h0, h, l[4:0]}, 16'd40, 16'd43);
    run_cnt(8'h01, 8'h04, 8'h00, 40);
    rng({h, l}, 16'd40, 16'd43);
    run_cnt(8'h02, 8'h04, 8'hF0, 20);
    rng({h, l}, 16'hF0F4, 16'hF0F8);
    run_cnt(8'h03, 8'h04, 8'h00, 20);
    chk({16'h0, h, l}, 32'h0);
  endtask

  // reset, then the scenarios one after another
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_wrap();
    t_count1();
    t_gate();
    t_modes();
    summarize();
  end

  // watchdog well beyond the under one thousand cycles the scenarios need
  initial begin
    #500us;
    err_count++;
    summarize();
  end
endmodule

// ### hw/dtc_pkg.sv
// package: constants and types of the dual counter/timer block
package dtc_pkg;
  // ----------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------
  localparam int DW      = 32;  // bus data width
  localparam int AW      = 32;  // bus address width
  localparam int AD      = 8;   // decoded address bits
  localparam int RW      = 8;   // register width
  localparam int NT      = 2;   // number of timers
  localparam int LO_BITS = 5;   // low-byte bits used in mode 0
  localparam int PSC_W   = 6;   // prescaler counter width

  // ----------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------
  localparam logic [AD-1:0] OFS_CTL  = 8'h00;  // run/overflow control
  localparam logic [AD-1:0] OFS_MODE = 8'h04;  // mode register
  localparam logic [AD-1:0] OFS_CLK  = 8'h08;  // clock control
  localparam logic [AD-1:0] OFS_ECFG = 8'h0C;  // ext irq config
  localparam logic [AD-1:0] OFS_IEN  = 8'h10;  // timer irq enables
  localparam logic [AD-1:0] OFS_C0L  = 8'h14;  // count 0 low byte
  localparam logic [AD-1:0] OFS_C0H  = 8'h18;  // count 0 high byte
  localparam logic [AD-1:0] OFS_C1L  = 8'h1C;  // count 1 low byte
  localparam logic [AD-1:0] OFS_C1H  = 8'h20;  // count 1 high byte
  localparam logic [AD-1:0] OFS_ISTS = 8'h24;  // sticky event status
  localparam logic [AD-1:0] OFS_IMSK = 8'h28;  // event mask

  // ----------------------------------------------------------
  // field positions; timer 1 sits one step above timer 0
  // ----------------------------------------------------------
  localparam int CTL_TF   = 5;  // overflow flag
  localparam int CTL_TR   = 4;  // run bit
  localparam int CTL_EF   = 1;  // external flag
  localparam int CTL_ET   = 0;  // external type
  localparam int CTL_STEP = 2;
  localparam int MD_SEL   = 0;  // two mode select bits
  localparam int MD_CT    = 2;  // counter/timer select
  localparam int MD_GATE  = 3;  // gate enable
  localparam int MD_STEP  = 4;
  localparam int CK_SCALE = 0;  // two clock scale bits
  localparam int CK_SYS   = 2;  // sysclk select, one per timer
  localparam int POL_BIT  = 3;  // ext irq polarity
  localparam int POL_STEP = 4;
  localparam int IEN_BIT  = 1;  // timer irq enable
  localparam int IEN_STEP = 2;
  localparam int SY_PIN   = 0;  // sync lanes of count pins
  localparam int SY_IRQ   = 2;  // sync lanes of ext irq inputs

  // ----------------------------------------------------------
  // reset values, prescaler divisors, bus codes
  // ----------------------------------------------------------
  localparam logic [RW-1:0]    REG_RST = 8'h00;
  localparam logic [PSC_W-1:0] DIV_0   = 6'h02;
  localparam logic [PSC_W-1:0] DIV_1   = 6'h04;
  localparam logic [PSC_W-1:0] DIV_2   = 6'h08;
  localparam logic [PSC_W-1:0] DIV_3   = 6'h10;
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_M8R, DTC_MHOLD} dtc_mode_t;
endpackage

// ### hw/dtc_timer.sv
`timescale 1ns/1ps
// dual 16-bit counter/timer with AHB-Lite register access

// Behaviour
// - two timers, sixteen-bit count in byte pairs
// - four modes per timer, set independently
// - mode 0 counts thirteen bits, five low
// - wrap sets overflow flag, requests interrupt
// - counter select counts count pin falls
// - timer select counts system or prescaled clock
// - count only when run and gate allow
// - gate input polarity set by config bit
// - run bit never clears or loads count
// - timer 1 mirrors timer 0, own inputs
// - shared control register layout, resets zero
// - overflow request gated by enable bit
// - overflow flag writable, cleared on vectoring
module dtc_timer (
  input  wire logic                     REF_CLK,
  input  wire logic                     RESETN,
  input  wire logic                     HSEL,
  input  wire logic [dtc_pkg::AW-1:0]   HADDR,
  input  wire logic [1:0]               HTRANS,
  input  wire logic                     HWRITE,
  input  wire logic [2:0]               HSIZE,
  input  wire logic [dtc_pkg::DW-1:0]   HWDATA,
  input  wire logic                     HREADY,
  output logic      [dtc_pkg::DW-1:0]   HRDATA,
  output logic                          HREADYOUT,
  output logic                          HRESP,
  input  wire logic                     COUNT_PIN_0,
  input  wire logic                     COUNT_PIN_1,
  input  wire logic                     EXT_IRQ_INPUT_0,
  input  wire logic                     EXT_IRQ_INPUT_1,
  input  wire logic                     VEC_ACK_0,
  input  wire logic                     VEC_ACK_1,
  output logic                          TIMER_A_IRQ,
  output logic                          TIMER_B_IRQ,
  output logic                          IRQ
);
  import dtc_pkg::*;

  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  logic              rd_pend_reg;
  logic              wr_pend_reg;
  logic [AD-1:0]     addr_reg;
  logic [DW-1:0]     hrdata_reg;
  logic              acc;
  logic [RW-1:0]     rd_byte;
  logic              we_ctl;
  logic              we_mode;
  logic              we_clk;
  logic              we_ecfg;
  logic              we_ien;
  logic              we_ists;
  logic              we_imsk;
  logic [NT-1:0]     we_lo;
  logic [NT-1:0]     we_hi;
  logic [RW-1:0]     ctl_reg;
  logic [RW-1:0]     ctl_next;
  logic [RW-1:0]     mode_reg;
  logic [RW-1:0]     clk_reg;
  logic [RW-1:0]     ecfg_reg;
  logic [RW-1:0]     ien_reg;
  logic [NT-1:0]     ists_reg;
  logic [NT-1:0]     ists_next;
  logic [NT-1:0]     imsk_reg;
  logic [RW-1:0]     lo_reg [NT];
  logic [RW-1:0]     hi_reg [NT];
  logic [3:0]        sync_in;
  logic [3:0]        s1_reg;
  logic [3:0]        s2_reg;
  logic [3:0]        s3_reg;
  logic [NT-1:0]     fall;
  logic [NT-1:0]     ack;
  logic [NT-1:0]     ovf;
  logic [NT-1:0]     irq_req;
  logic [PSC_W-1:0]  psc_reg;
  logic [PSC_W-1:0]  psc_div;
  logic              psc_stb;

  // address compare used by every register strobe and the read mux
  function automatic logic dec(input logic [AD-1:0] a, input logic [AD-1:0] o);
    dec = (a == o);
  endfunction

  // prescaler divisor chosen by the clock scale bits
  function automatic logic [PSC_W-1:0] div_sel(input logic [1:0] s);
    case (s)
      2'h0:    div_sel = DIV_0;
      2'h1:    div_sel = DIV_1;
      2'h2:    div_sel = DIV_2;
      default: div_sel = DIV_3;
    endcase
  endfunction

  // ----------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------

  // address phase taken only on a selected NONSEQ with HREADY high
  assign acc       = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);
  assign HREADYOUT = ~rd_pend_reg;  // reads take one wait state
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_reg;

  // data phase bookkeeping
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_pend_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      addr_reg    <= REG_RST;
    end else begin
      rd_pend_reg <= acc & ~HWRITE;
      wr_pend_reg <= acc & HWRITE;
      if (acc) begin
        addr_reg <= HADDR[AD-1:0];
      end
    end
  end

  // write strobes, committed at the end of the data phase
  assign we_ctl  = wr_pend_reg & dec(addr_reg, OFS_CTL);
  assign we_mode = wr_pend_reg & dec(addr_reg, OFS_MODE);
  assign we_clk  = wr_pend_reg & dec(addr_reg, OFS_CLK);
  assign we_ecfg = wr_pend_reg & dec(addr_reg, OFS_ECFG);
  assign we_ien  = wr_pend_reg & dec(addr_reg, OFS_IEN);
  assign we_ists = wr_pend_reg & dec(addr_reg, OFS_ISTS);
  assign we_imsk = wr_pend_reg & dec(addr_reg, OFS_IMSK);
  assign we_lo   = {wr_pend_reg & dec(addr_reg, OFS_C1L), wr_pend_reg & dec(addr_reg, OFS_C0L)};
  assign we_hi   = {wr_pend_reg & dec(addr_reg, OFS_C1H), wr_pend_reg & dec(addr_reg, OFS_C0H)};

  // read selection; unmapped offsets read zero
  assign rd_byte = dec(addr_reg, OFS_CTL)  ? ctl_reg  :
                   dec(addr_reg, OFS_MODE) ? mode_reg :
                   dec(addr_reg, OFS_CLK)  ? clk_reg  :
                   dec(addr_reg, OFS_ECFG) ? ecfg_reg :
                   dec(addr_reg, OFS_IEN)  ? ien_reg  :
                   dec(addr_reg, OFS_C0L)  ? lo_reg[0] :
                   dec(addr_reg, OFS_C0H)  ? hi_reg[0] :
                   dec(addr_reg, OFS_C1L)  ? lo_reg[1] :
                   dec(addr_reg, OFS_C1H)  ? hi_reg[1] :
                   dec(addr_reg, OFS_ISTS) ? {{(RW-NT){1'b0}}, ists_reg} :
                   dec(addr_reg, OFS_IMSK) ? {{(RW-NT){1'b0}}, imsk_reg} :
                   REG_RST;

  // read data sampled in the wait state
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hrdata_reg <= '0;
    end else if (rd_pend_reg) begin
      hrdata_reg <= {{(DW-RW){1'b0}}, rd_byte};
    end
  end

  // ----------------------------------------------------------
  // configuration and interrupt registers
  // ----------------------------------------------------------

  // plain read/write configuration
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_reg <= REG_RST;
      clk_reg  <= REG_RST;
      ecfg_reg <= REG_RST;
      ien_reg  <= REG_RST;
      imsk_reg <= '0;
    end else begin
      if (we_mode) mode_reg <= HWDATA[RW-1:0];
      if (we_clk)  clk_reg  <= HWDATA[RW-1:0];
      if (we_ecfg) ecfg_reg <= HWDATA[RW-1:0];
      if (we_ien)  ien_reg  <= HWDATA[RW-1:0];
      if (we_imsk) imsk_reg <= HWDATA[NT-1:0];
    end
  end

  // shared control register and sticky overflow events
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_reg  <= REG_RST;
      ists_reg <= '0;
    end else begin
      ctl_reg  <= ctl_next;
      ists_reg <= ists_next;
    end
  end

  // event set wins over write-one-to-clear
  assign ists_next = ovf | (ists_reg & ~({NT{we_ists}} & HWDATA[NT-1:0]));
  assign IRQ       = |(ists_reg & imsk_reg);
  assign ack       = {VEC_ACK_1, VEC_ACK_0};
  assign TIMER_A_IRQ = irq_req[0];
  assign TIMER_B_IRQ = irq_req[1];

  // ----------------------------------------------------------
  // input synchroniser and prescaler
  // ----------------------------------------------------------

  // three stages: two to synchronise, one to find edges
  assign sync_in = {EXT_IRQ_INPUT_1, EXT_IRQ_INPUT_0, COUNT_PIN_1, COUNT_PIN_0};
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= sync_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign fall = s3_reg[SY_PIN +: NT] & ~s2_reg[SY_PIN +: NT];

  // free-running divider; strobe is one cycle wide
  assign psc_div = div_sel(clk_reg[CK_SCALE +: 2]);
  assign psc_stb = (psc_reg == psc_div - 6'h01);
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      psc_reg <= '0;
    end else begin
      psc_reg <= (psc_stb | (psc_reg >= psc_div)) ? '0 : psc_reg + 6'h01;
    end
  end

  chk_presc_one_wide: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    psc_stb |=> !psc_stb) else $error("prescaler strobe wider than one cycle");

  // ----------------------------------------------------------
  // timers, one generate instance each
  // ----------------------------------------------------------
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    localparam int MB = MD_STEP * i;
    localparam int CB = CTL_STEP * i;
    dtc_mode_t           md;
    logic                ct;
    logic                gate;
    logic                pol;
    logic                act;
    logic                act_d;
    logic                en;
    logic                tick;
    logic                tf;
    logic                ef;
    logic                et;
    logic [RW+LO_BITS-1:0] c13;
    logic [2*RW-1:0]     c16;
    logic [RW-1:0]       lo_n;
    logic [RW-1:0]       hi_n;

    // mode decode, each timer from its own nibble
    assign md   = dtc_mode_t'(mode_reg[MB+MD_SEL +: 2]);
    assign ct   = mode_reg[MB+MD_CT];
    assign gate = mode_reg[MB+MD_GATE];
    assign pol  = ecfg_reg[POL_BIT+POL_STEP*i];
    assign act   = pol ? s2_reg[SY_IRQ+i] : ~s2_reg[SY_IRQ+i];
    assign act_d = pol ? s3_reg[SY_IRQ+i] : ~s3_reg[SY_IRQ+i];
    assign en   = ctl_reg[CTL_TR+CB] & (~gate | act);
    assign tick = en & (ct ? fall[i] : (clk_reg[CK_SYS+i] | psc_stb));
    assign tf   = ctl_reg[CTL_TF+CB];
    assign ef   = ctl_reg[CTL_EF+CB];
    assign et   = ctl_reg[CTL_ET+CB];

    // increments for the 13-bit and 16-bit widths
    assign c13 = {hi_reg[i], lo_reg[i][LO_BITS-1:0]} + 13'h0001;
    assign c16 = {hi_reg[i], lo_reg[i]} + 16'h0001;

    // overflow on the wrap from all ones
    assign ovf[i] = tick & ((md == DTC_M13) ? &{hi_reg[i], lo_reg[i][LO_BITS-1:0]} :
                            (md == DTC_M16) ? &{hi_reg[i], lo_reg[i]} :
                            (md == DTC_M8R) ? &lo_reg[i] : 1'b0);

    // next count per mode; upper low-byte bits left alone in mode 0
    always_comb begin
      lo_n = lo_reg[i];
      hi_n = hi_reg[i];
      case (md)
        DTC_M13: begin
          lo_n = {lo_reg[i][RW-1:LO_BITS], c13[LO_BITS-1:0]};
          hi_n = c13[RW+LO_BITS-1:LO_BITS];
        end
        DTC_M16: begin
          lo_n = c16[RW-1:0];
          hi_n = c16[2*RW-1:RW];
        end
        DTC_M8R: begin
          lo_n = (&lo_reg[i]) ? hi_reg[i] : lo_reg[i] + 8'h01;
        end
        default: begin
          lo_n = lo_reg[i];
        end
      endcase
    end

    // count bytes; a software load beats a tick, run never loads
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        lo_reg[i] <= REG_RST;
        hi_reg[i] <= REG_RST;
      end else begin
        if (we_lo[i]) lo_reg[i] <= HWDATA[RW-1:0];
        else if (tick) lo_reg[i] <= lo_n;
        if (we_hi[i]) hi_reg[i] <= HWDATA[RW-1:0];
        else if (tick) hi_reg[i] <= hi_n;
      end
    end

    // control bits of this timer; hardware set wins
    assign ctl_next[CTL_TF+CB] = ovf[i] | (we_ctl ? HWDATA[CTL_TF+CB] : (tf & ~ack[i]));
    assign ctl_next[CTL_TR+CB] = we_ctl ? HWDATA[CTL_TR+CB] : ctl_reg[CTL_TR+CB];
    assign ctl_next[CTL_EF+CB] = et ? ((act & ~act_d) | (we_ctl ? HWDATA[CTL_EF+CB] : ef)) : act;
    assign ctl_next[CTL_ET+CB] = we_ctl ? HWDATA[CTL_ET+CB] : et;
    assign irq_req[i] = tf & ien_reg[IEN_BIT+IEN_STEP*i];

    // a synchronised high then low gives the fall strobe
    sequence pin_fall_s;
      s2_reg[SY_PIN+i] ##1 !s2_reg[SY_PIN+i];
    endsequence

    // the strobe rises in the cycle that the synchronised low first shows
    chk_pin_fall_strobe: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      pin_fall_s |-> fall[i] ##1 !fall[i]) else $error("count pin fall strobe wrong");
    chk_counter_pin: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (en & ct & fall[i] & !we_lo[i] & !we_hi[i] & md == DTC_M13)
        |=> {hi_reg[i], lo_reg[i][LO_BITS-1:0]} == $past({hi_reg[i], lo_reg[i][LO_BITS-1:0]}) + 13'h0001)
      else $error("count pin fall did not increment");
    chk_run_off_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (!ctl_reg[CTL_TR+CB] & !we_lo[i] & !we_hi[i]) |=> $stable(lo_reg[i]) && $stable(hi_reg[i]))
      else $error("count moved with run bit low");
    chk_gate_polarity: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (ctl_reg[CTL_TR+CB] & gate & !ct & clk_reg[CK_SYS+i])
        |-> tick == (s2_reg[SY_IRQ+i] == pol)) else $error("gate polarity ignored");
    chk_m13_wrap: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (tick & md == DTC_M13 & &{hi_reg[i], lo_reg[i][LO_BITS-1:0]} & !we_lo[i] & !we_hi[i])
        |=> hi_reg[i] == 8'h00 && lo_reg[i][LO_BITS-1:0] == 5'h00 && tf)
      else $error("13-bit wrap or flag wrong");
    chk_ack_clears: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (ack[i] & !ovf[i] & !we_ctl) |=> !tf) else $error("vectoring left flag set");
    chk_set_wins: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (ovf[i] & (ack[i] | we_ctl)) |=> tf && ists_reg[i]) else $error("overflow lost to clear");
    chk_irq_enable: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (ovf[i] & !we_ien & !we_ctl) |=> irq_req[i] == ien_reg[IEN_BIT+IEN_STEP*i])
      else $error("timer request not gated by enable");
    chk_run_no_load: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      (we_ctl & HWDATA[CTL_TR+CB] & !ctl_reg[CTL_TR+CB] & !we_lo[i] & !we_hi[i])
        |=> $stable(lo_reg[i]) && $stable(hi_reg[i])) else $error("run bit loaded the count");
  end

endmodule
